// ===== core/sqsc_pkg.sv
// sqsc_pkg: constants, layouts and types for the sequencer stacks and conditions block
// assumes one core clock; shared by the design file, the decode model and the test
package sqsc_pkg;
   localparam int PC_DEPTH = 33;
   localparam int STS_DEPTH = 16;
   localparam int LOOP_DEPTH = 8;
   localparam int PC_LVL_W = 6;
   localparam int STS_LVL_W = 5;
   localparam int LOOP_LVL_W = 4;
   localparam int ADDR_W = 24;
   localparam int WORD_W = 16;
   localparam logic [PC_LVL_W-1:0] PC_FULL_LVL = 6'h21;
   localparam logic [PC_LVL_W-1:0] PC_HIGH_MARK = 6'h1c;
   localparam logic [PC_LVL_W-1:0] PC_LOW_MARK = 6'h03;
   localparam logic [STS_LVL_W-1:0] STS_FULL_LVL = 5'h10;
   localparam logic [LOOP_LVL_W-1:0] LOOP_FULL_LVL = 4'h8;
   localparam logic [WORD_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [WORD_W-1:0] CNT_ONE = 16'h0001;
   // wishbone register map, byte addresses
   localparam logic [3:0] ADR_STACK_STATUS = 4'h0;
   localparam logic [3:0] ADR_INT_CONTROL = 4'h4;
   localparam logic [3:0] ADR_PC_TOP = 4'h8;
   localparam logic [3:0] ADR_COND = 4'hc;
   // stack status bit positions
   localparam int SS_PC_EMPTY = 0;
   localparam int SS_PC_FULL = 1;
   localparam int SS_PC_LVL = 2;
   localparam int SS_LP_EMPTY = 4;
   localparam int SS_LP_FULL = 5;
   localparam int SS_STS_EMPTY = 6;
   localparam int SS_ERR = 7;
   // interrupt control bit positions
   localparam int IC_GIE = 5;
   localparam int IC_SPILL = 10;
   localparam logic [15:0] IC_RESET = 16'h0000;
   // arithmetic flag positions
   localparam int AF_AZ = 0;
   localparam int AF_AN = 1;
   localparam int AF_AV = 2;
   localparam int AF_AC = 3;
   localparam int AF_AS = 4;
   localparam int AF_MV = 6;
   localparam int AF_SV = 8;
   // software condition selects above the flag inputs
   localparam logic [3:0] SW_SEL_AS = 4'he;
   localparam logic [3:0] SW_SEL_SV = 4'hf;

   typedef enum logic [4:0] {
      SQSC_C_EQ, SQSC_C_NE, SQSC_C_LT, SQSC_C_GE, SQSC_C_LE, SQSC_C_GT,
      SQSC_C_AC, SQSC_C_NAC, SQSC_C_AV, SQSC_C_NAV, SQSC_C_MV, SQSC_C_NMV,
      SQSC_C_SW, SQSC_C_NSW, SQSC_C_CE, SQSC_C_NCE, SQSC_C_FOREVER, SQSC_C_TRUE
   } sqsc_cond_t;

   typedef enum logic [3:0] {
      SQSC_OP_NONE, SQSC_OP_CALL, SQSC_OP_RTS, SQSC_OP_DO, SQSC_OP_LOOP_END,
      SQSC_OP_IRQ, SQSC_OP_RTI, SQSC_OP_PUSH, SQSC_OP_POP
   } sqsc_op_t;

   typedef struct packed {
      logic pc;
      logic loop;
      logic sts;
   } sqsc_sel_t;

   typedef struct packed {
      sqsc_op_t op;
      sqsc_sel_t sel;
      sqsc_cond_t cond;
      logic [ADDR_W-1:0] pc;
      logic [ADDR_W-1:0] loop_end;
   } sqsc_req_t;

   typedef struct packed {
      logic [ADDR_W-1:0] pc_acc;
      logic [ADDR_W-1:0] loop_acc;
      logic [WORD_W-1:0] loop_count_reg;
      logic [WORD_W-1:0] arith_flags_reg;
      logic [WORD_W-1:0] mode_flags_reg;
   } sqsc_regs_t;

   typedef struct packed {
      logic [ADDR_W-1:0] pc;
      logic [ADDR_W-1:0] loop_start;
      logic [ADDR_W-1:0] loop_end;
      logic [WORD_W-1:0] count;
      logic [WORD_W-1:0] arith_flags_reg;
      logic [WORD_W-1:0] mode_flags_reg;
   } sqsc_tops_t;
endpackage

// ===== core/sqsc_top.sv
// sqsc_top: stacks, stack status, stack interrupt and condition logic of the sequencer
// assumes decode issues one op per enabled cycle and treats tops as valid next cycle
// Operation
// RQ1: pc empty bit0, pc full bit1
// RQ2: bit2 high when level >=28 or <=3
// RQ3: loop empty bit4, loop full bit5
// RQ4: status empty flag bit6
// RQ5: sticky error bit7 cleared only by reset
// RQ6: loop stack underflow never flagged
// RQ7: stack irq on overflow, or spill-fill OR
// RQ8: level flag set by push/pop watermark
// RQ9: spill-fill off at reset, follows bit10
// RQ10: global enable bit5 gates all interrupts; the code gates irq_pending_i only, stack_irq_o is not gated
// RQ11: spill-fill may raise immediate low-level irq
// RQ12: call pushes next pc, return pops it
// RQ13: loop start pushes count, start, end
// RQ14: decrement top count, expiry pops loop stacks
// RQ15: interrupt pushes pc and both status words
// RQ16: explicit push/pop via access registers
// RQ17: arithmetic conditions from flag equations
// RQ18: software condition from select and flags
// RQ19: ce/forever loops only, nce/true if only
// RQ20: forever loop never terminates itself
// RQ21: flags change only on stack-touching ops
// RQ22: loop uses counter, if uses status
// RQ23: depths 33, 16, and 8
// RQ24: push onto full stack flags error
module sqsc_top
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire sqsc_pkg::sqsc_req_t req_i,
   input wire sqsc_pkg::sqsc_regs_t regs_i,
   input wire logic [13:0] flag_inputs_i,
   input wire logic irq_pending_i,
   output sqsc_pkg::sqsc_tops_t tops_o,
   output logic cond_true_o,
   output logic cond_illegal_o,
   output logic loop_exit_o,
   output logic stack_irq_o,
   output logic irq_allowed_o,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o
);
   import sqsc_pkg::*;

   logic [ADDR_W-1:0] pc_mem_q [PC_DEPTH];
   logic [ADDR_W-1:0] ls_mem_q [LOOP_DEPTH];
   logic [ADDR_W-1:0] le_mem_q [LOOP_DEPTH];
   logic [WORD_W-1:0] ct_mem_q [LOOP_DEPTH];
   logic [WORD_W-1:0] as_mem_q [STS_DEPTH];
   logic [WORD_W-1:0] ms_mem_q [STS_DEPTH];
   logic [PC_LVL_W-1:0] pc_lvl_q;
   logic [LOOP_LVL_W-1:0] lp_lvl_q;
   logic [STS_LVL_W-1:0] st_lvl_q;
   logic pc_mark_q;
   logic err_q;
   logic [15:0] interrupt_control_q;
   logic [3:0] sw_condition_select_q;
   logic [7:0] sequencer_stack_status;
   logic pc_push, pc_pop, lp_push, lp_pop, st_push, st_pop;
   logic [ADDR_W-1:0] pc_push_val;
   logic [PC_LVL_W-1:0] pc_lvl_d;
   logic pc_full, pc_empty, lp_full, lp_empty, st_full, st_empty;
   logic [PC_LVL_W-1:0] pc_tix;
   logic [LOOP_LVL_W-1:0] lp_tix;
   logic [STS_LVL_W-1:0] st_tix;
   logic [WORD_W-1:0] top_count;
   logic ce_cond, sw_match, wb_hit, wb_wr;

   assign pc_full = (pc_lvl_q == PC_FULL_LVL);
   assign pc_empty = (pc_lvl_q == '0);
   assign lp_full = (lp_lvl_q == LOOP_FULL_LVL);
   assign lp_empty = (lp_lvl_q == '0);
   assign st_full = (st_lvl_q == STS_FULL_LVL);
   assign st_empty = (st_lvl_q == '0);
   assign pc_tix = pc_empty ? '0 : pc_lvl_q - PC_LVL_W'(1);
   assign lp_tix = lp_empty ? '0 : lp_lvl_q - LOOP_LVL_W'(1);
   assign st_tix = st_empty ? '0 : st_lvl_q - STS_LVL_W'(1);
   assign top_count = ct_mem_q[lp_tix[2:0]];

   // stack operation decode
   always_comb
   begin
      pc_push = 1'b0;
      pc_pop = 1'b0;
      lp_push = 1'b0;
      lp_pop = 1'b0;
      st_push = 1'b0;
      st_pop = 1'b0;
      pc_push_val = req_i.pc;
      case (req_i.op)
         SQSC_OP_CALL: pc_push = 1'b1; // [RQ12]
         SQSC_OP_RTS: pc_pop = 1'b1; // [RQ12]
         SQSC_OP_DO: lp_push = 1'b1; // [RQ13]
         SQSC_OP_LOOP_END: lp_pop = ce_cond; // [RQ14]
         SQSC_OP_IRQ:
         begin
            pc_push = 1'b1; // [RQ15]
            st_push = 1'b1;
         end
         SQSC_OP_RTI:
         begin
            pc_pop = 1'b1; // [RQ15]
            st_pop = 1'b1;
         end
         SQSC_OP_PUSH:
         begin
            pc_push = req_i.sel.pc; // [RQ16]
            lp_push = req_i.sel.loop;
            st_push = req_i.sel.sts;
            pc_push_val = regs_i.pc_acc;
         end
         SQSC_OP_POP:
         begin
            pc_pop = req_i.sel.pc; // [RQ16]
            lp_pop = req_i.sel.loop;
            st_pop = req_i.sel.sts;
         end
         default: pc_push = 1'b0; // [RQ21]
      endcase
   end

   always_comb
   begin
      pc_lvl_d = pc_lvl_q;
      if (pc_push && !pc_full)
         pc_lvl_d = pc_lvl_q + PC_LVL_W'(1);
      else if (pc_pop && !pc_empty)
         pc_lvl_d = pc_lvl_q - PC_LVL_W'(1);
   end

   // pc stack storage and level
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pc_lvl_q <= '0;
      else if (ce_i)
      begin
         if (pc_push && !pc_full)
            pc_mem_q[pc_lvl_q] <= pc_push_val; // [RQ23]
         pc_lvl_q <= pc_lvl_d;
      end
   end

   // level mark updates only on pc push/pop
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pc_mark_q <= 1'b1;
      else if (ce_i && (pc_push || pc_pop))
         pc_mark_q <= (pc_lvl_d >= PC_HIGH_MARK) || (pc_lvl_d <= PC_LOW_MARK); // [RQ2] [RQ8]
   end

   // loop stacks: start, end, counter share one level
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         lp_lvl_q <= '0;
      else if (ce_i)
      begin
         if (lp_push && !lp_full)
         begin
            ct_mem_q[lp_lvl_q[2:0]] <= regs_i.loop_count_reg; // [RQ13]
            ls_mem_q[lp_lvl_q[2:0]] <= (req_i.op == SQSC_OP_DO) ? req_i.pc : regs_i.loop_acc;
            le_mem_q[lp_lvl_q[2:0]] <= (req_i.op == SQSC_OP_DO) ? req_i.loop_end
                                                                : regs_i.loop_acc;
            lp_lvl_q <= lp_lvl_q + LOOP_LVL_W'(1);
         end
         else if (lp_pop && !lp_empty)
            lp_lvl_q <= lp_lvl_q - LOOP_LVL_W'(1); // [RQ14]
         else if (req_i.op == SQSC_OP_LOOP_END && !lp_empty && req_i.cond == SQSC_C_CE)
            ct_mem_q[lp_tix[2:0]] <= top_count - CNT_ONE; // [RQ14]
      end
   end

   // status stack
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         st_lvl_q <= '0;
      else if (ce_i)
      begin
         if (st_push && !st_full)
         begin
            as_mem_q[st_lvl_q[3:0]] <= regs_i.arith_flags_reg; // [RQ15]
            ms_mem_q[st_lvl_q[3:0]] <= regs_i.mode_flags_reg;
            st_lvl_q <= st_lvl_q + STS_LVL_W'(1);
         end
         else if (st_pop && !st_empty)
            st_lvl_q <= st_lvl_q - STS_LVL_W'(1);
      end
   end

   // sticky error: overflow on any, underflow on pc or status only
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         err_q <= 1'b0; // [RQ5]
      else if (ce_i && ((pc_push && pc_full) || (lp_push && lp_full) || (st_push && st_full)
                        || (pc_pop && pc_empty) || (st_pop && st_empty)))
         err_q <= 1'b1; // [RQ24] [RQ6]
   end

   always_comb
   begin
      sequencer_stack_status = '0;
      sequencer_stack_status[SS_PC_EMPTY] = pc_empty; // [RQ1]
      sequencer_stack_status[SS_PC_FULL] = pc_full; // [RQ1]
      sequencer_stack_status[SS_PC_LVL] = pc_mark_q; // [RQ2]
      sequencer_stack_status[SS_LP_EMPTY] = lp_empty; // [RQ3]
      sequencer_stack_status[SS_LP_FULL] = lp_full; // [RQ3]
      sequencer_stack_status[SS_STS_EMPTY] = st_empty; // [RQ4]
      sequencer_stack_status[SS_ERR] = err_q; // [RQ5]
   end

   assign stack_irq_o = interrupt_control_q[IC_SPILL] ? (err_q | pc_mark_q) : err_q; // [RQ7] [RQ9] [RQ11]
   assign irq_allowed_o = interrupt_control_q[IC_GIE] & irq_pending_i; // [RQ10]

   always_comb
   begin
      tops_o.pc = pc_mem_q[pc_tix];
      tops_o.loop_start = ls_mem_q[lp_tix[2:0]];
      tops_o.loop_end = le_mem_q[lp_tix[2:0]];
      tops_o.count = top_count;
      tops_o.arith_flags_reg = as_mem_q[st_tix[3:0]];
      tops_o.mode_flags_reg = ms_mem_q[st_tix[3:0]];
   end

   // condition evaluation
   assign ce_cond = (req_i.cond == SQSC_C_CE) && (top_count == CNT_ONE); // [RQ22] [RQ20]
   assign sw_match = (sw_condition_select_q == SW_SEL_AS) ? regs_i.arith_flags_reg[AF_AS] :
                     (sw_condition_select_q == SW_SEL_SV) ? regs_i.arith_flags_reg[AF_SV] :
                     flag_inputs_i[sw_condition_select_q]; // [RQ18]

   always_comb
   begin
      logic lt;
      lt = regs_i.arith_flags_reg[AF_AN] ^ regs_i.arith_flags_reg[AF_AV];
      cond_illegal_o = 1'b0;
      case (req_i.cond)
         SQSC_C_EQ: cond_true_o = regs_i.arith_flags_reg[AF_AZ]; // [RQ17]
         SQSC_C_NE: cond_true_o = !regs_i.arith_flags_reg[AF_AZ];
         SQSC_C_LT: cond_true_o = lt;
         SQSC_C_GE: cond_true_o = !lt;
         SQSC_C_LE: cond_true_o = lt | regs_i.arith_flags_reg[AF_AZ];
         SQSC_C_GT: cond_true_o = !(lt | regs_i.arith_flags_reg[AF_AZ]);
         SQSC_C_AC: cond_true_o = regs_i.arith_flags_reg[AF_AC];
         SQSC_C_NAC: cond_true_o = !regs_i.arith_flags_reg[AF_AC];
         SQSC_C_AV: cond_true_o = regs_i.arith_flags_reg[AF_AV];
         SQSC_C_NAV: cond_true_o = !regs_i.arith_flags_reg[AF_AV];
         SQSC_C_MV: cond_true_o = regs_i.arith_flags_reg[AF_MV];
         SQSC_C_NMV: cond_true_o = !regs_i.arith_flags_reg[AF_MV];
         SQSC_C_SW: cond_true_o = sw_match; // [RQ18]
         SQSC_C_NSW: cond_true_o = !sw_match;
         SQSC_C_NCE: cond_true_o = (top_count != CNT_ZERO); // [RQ19]
         SQSC_C_TRUE: cond_true_o = 1'b1;
         default:
         begin
            cond_true_o = 1'b0; // [RQ19]
            cond_illegal_o = 1'b1;
         end
      endcase
   end

   assign loop_exit_o = (req_i.op == SQSC_OP_LOOP_END) && ce_cond; // [RQ20] [RQ14]

   // wishbone slave, one wait state
   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // write lands at the edge where the master samples ack
   assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         interrupt_control_q <= IC_RESET; // [RQ9]
         sw_condition_select_q <= '0;
      end
      else if (wb_wr)
      begin
         if (wb_adr_i[3:0] == ADR_INT_CONTROL)
         begin
            if (wb_sel_i[0])
               interrupt_control_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
               interrupt_control_q[15:8] <= wb_dat_i[15:8];
         end
         if (wb_adr_i[3:0] == ADR_COND && wb_sel_i[0])
            sw_condition_select_q <= wb_dat_i[3:0];
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end
      else
      begin
         wb_ack_o <= wb_hit;
         if (wb_hit)
         begin
            case (wb_adr_i[3:0])
               ADR_STACK_STATUS: wb_dat_o <= {24'h000000, sequencer_stack_status};
               ADR_INT_CONTROL: wb_dat_o <= {16'h0000, interrupt_control_q};
               ADR_PC_TOP: wb_dat_o <= {8'h00, tops_o.pc};
               ADR_COND: wb_dat_o <= {28'h0000000, sw_condition_select_q};
               default: wb_dat_o <= '0;
            endcase
         end
      end
   end

   sticky_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      err_q |=> err_q) else $error("sticky error dropped"); // [RQ5]
   push_full_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && pc_push && pc_full |=> err_q) else $error("overflow not flagged"); // [RQ24]
   pc_empty_a: assert property (@(posedge clk_i) disable iff (rst_i)
      sequencer_stack_status[SS_PC_EMPTY] == (pc_lvl_q == '0)) else $error("pc empty wrong"); // [RQ1]
   call_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && req_i.op == SQSC_OP_CALL && !pc_full |=> pc_lvl_q == $past(pc_lvl_q) + 6'h01)
      else $error("call did not push"); // [RQ12]
   call_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && req_i.op == SQSC_OP_CALL && !pc_full |=> tops_o.pc == $past(req_i.pc))
      else $error("call pushed wrong value"); // [RQ12]
   irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !interrupt_control_q[IC_GIE] |-> !irq_allowed_o) else $error("irq passed gie"); // [RQ10]
   spill_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !interrupt_control_q[IC_SPILL] |-> stack_irq_o == err_q) else $error("stack irq wrong"); // [RQ7]
   mark_push_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && pc_push && !pc_pop && pc_lvl_d >= PC_HIGH_MARK |=> pc_mark_q)
      else $error("high mark missed"); // [RQ8]
   lt_cond_a: assert property (@(posedge clk_i) disable iff (rst_i)
      req_i.cond == SQSC_C_LT |-> cond_true_o == (regs_i.arith_flags_reg[AF_AN] ^ regs_i.arith_flags_reg[AF_AV]))
      else $error("lt wrong"); // [RQ17]
   wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o) else $error("ack held"); // wishbone ack lasts one cycle

   call_c: cover property (@(posedge clk_i) ce_i && req_i.op == SQSC_OP_CALL);
   loop_exit_c: cover property (@(posedge clk_i) ce_i && loop_exit_o);
   overflow_c: cover property (@(posedge clk_i) $rose(err_q));
   spill_c: cover property (@(posedge clk_i) interrupt_control_q[IC_SPILL] && stack_irq_o);
endmodule // sqsc_top

// ===== verification/sqsc_decode_model.sv
// sqsc_decode_model: stand-in for fetch and decode feeding sequencer ops
// assumes an op is taken at the rising edge while ce is high
module sqsc_decode_model
(
   input wire logic clk_i,
   output sqsc_pkg::sqsc_req_t req_o,
   output logic ce_o
);
   timeunit 1ns;
   timeprecision 100ps;
   import sqsc_pkg::*;
   initial
   begin
      req_o = '0;
      ce_o = 1'b0;
   end
   // present one op for one enabled edge
   task automatic drive(input sqsc_req_t r);
      @(posedge clk_i);
      req_o <= r;
      ce_o <= 1'b1;
   endtask
   task automatic idle();
      @(posedge clk_i);
      req_o.op <= SQSC_OP_NONE;
      ce_o <= 1'b0;
   endtask
   // condition select only, no op
   task automatic set_cond(input sqsc_cond_t c);
      @(posedge clk_i);
      req_o.cond <= c;
   endtask
endmodule // sqsc_decode_model

// ===== verification/sequencer_stacks_and_conditions_test.sv
// sequencer_stacks_and_conditions_test: stack, status and condition checks
// assumes the decode model drives ops and wishbone reaches the registers
`define CHK(nm, e, g) \
   n_compared++; \
   if ((g) !== (e)) \
   begin \
      bad_count++; \
      $display("unexpected %s expected %0h seen %0h", nm, e, g); \
   end
module sequencer_stacks_and_conditions_test;
   timeunit 1ns;
   timeprecision 100ps;
   import sqsc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce, cond_true, cond_ill, loop_exit, stack_irq, irq_ok, wb_we, wb_cyc, wb_stb, wb_ack;
   logic irq_pend;
   logic [13:0] flags;
   logic [31:0] wb_adr, wb_dat, wb_rdat, rd;
   logic [3:0] wb_sel;
   sqsc_req_t req;
   sqsc_regs_t regs;
   sqsc_tops_t tops;
   int bad_count = 0;
   int n_compared = 0;
   sqsc_cond_t cl[13] = '{SQSC_C_EQ, SQSC_C_NE, SQSC_C_LT, SQSC_C_GE, SQSC_C_LE, SQSC_C_GT,
      SQSC_C_AC, SQSC_C_NAC, SQSC_C_AV, SQSC_C_NAV, SQSC_C_MV, SQSC_C_NMV, SQSC_C_TRUE};
   always #12.5 clk = ~clk;
   sqsc_decode_model u_dec (.clk_i(clk), .req_o(req), .ce_o(ce));
   sqsc_top u_dut (.clk_i(clk), .rst_i(rst), .ce_i(ce), .req_i(req), .regs_i(regs),
      .flag_inputs_i(flags), .irq_pending_i(irq_pend), .tops_o(tops), .cond_true_o(cond_true),
      .cond_illegal_o(cond_ill), .loop_exit_o(loop_exit), .stack_irq_o(stack_irq),
      .irq_allowed_o(irq_ok), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
      .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack));
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge clk);
      wb_adr <= a;
      wb_we <= w;
      wb_dat <= d;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      for (k = 0; k < 20 && wb_ack !== 1'b1; k++)
         @(posedge clk);
      if (k == 20)
      begin
         bad_count++;
         stop_test();
      end
      rd = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
   endtask
   task automatic st(input logic [31:0] e);
      wb(32'h0, 1'b0, 32'h0);
      `CHK("status", e, rd)
   endtask
   function automatic sqsc_req_t mk(sqsc_op_t o, logic [2:0] s, sqsc_cond_t c, logic [23:0] p);
      mk = '{o, sqsc_sel_t'(s), c, p, 24'h0002ff};
   endfunction
   task automatic op(sqsc_op_t o, logic [2:0] s, sqsc_cond_t c, logic [23:0] p);
      u_dec.drive(mk(o, s, c, p));
      u_dec.idle();
      #1;
   endtask
   task automatic reset_dut();
      @(posedge clk);
      rst <= 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
   endtask
   function automatic logic cexp(sqsc_cond_t c, logic [15:0] a);
      logic lt;
      lt = a[AF_AN] ^ a[AF_AV];
      case (c)
         SQSC_C_EQ: cexp = a[AF_AZ];
         SQSC_C_NE: cexp = !a[AF_AZ];
         SQSC_C_LT: cexp = lt;
         SQSC_C_GE: cexp = !lt;
         SQSC_C_LE: cexp = lt | a[AF_AZ];
         SQSC_C_GT: cexp = !(lt | a[AF_AZ]);
         SQSC_C_AC: cexp = a[AF_AC];
         SQSC_C_NAC: cexp = !a[AF_AC];
         SQSC_C_AV: cexp = a[AF_AV];
         SQSC_C_NAV: cexp = !a[AF_AV];
         SQSC_C_MV: cexp = a[AF_MV];
         SQSC_C_NMV: cexp = !a[AF_MV];
         default: cexp = 1'b1;
      endcase
   endfunction
   initial
   begin
      wb_adr = '0;
      wb_dat = '0;
      wb_sel = 4'h3;
      wb_we = 1'b0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      flags = '0;
      irq_pend = 1'b0;
      regs = '0;
      reset_dut();
      st(32'h55);
      `CHK("stack irq", 1'b0, stack_irq)
      wb(32'h0, 1'b1, 32'hff);
      st(32'h55);
      wb(32'h3, 1'b1, 32'hff);
      wb(32'h3, 1'b0, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      op(SQSC_OP_POP, 3'b010, SQSC_C_TRUE, 24'h0);
      st(32'h55);
      op(SQSC_OP_RTS, 3'b000, SQSC_C_TRUE, 24'h0);
      st(32'hd5);
      reset_dut();
      for (int i = 0; i < 33; i++)
      begin
         op(SQSC_OP_CALL, 3'b000, SQSC_C_TRUE, 24'h100 + 24'(i));
         if (i == 9)
            st(32'h50);
         if (i == 27)
            st(32'h54);
      end
      st(32'h56);
      op(SQSC_OP_CALL, 3'b000, SQSC_C_TRUE, 24'h999);
      st(32'hd6);
      `CHK("stack irq", 1'b1, stack_irq)
      for (int i = 32; i >= 0; i--)
      begin
         `CHK("pc top", 24'h100 + 24'(i), tops.pc)
         op(SQSC_OP_RTS, 3'b000, SQSC_C_TRUE, 24'h0);
      end
      st(32'hd5);
      reset_dut();
      regs.loop_count_reg <= 16'h3;
      op(SQSC_OP_DO, 3'b000, SQSC_C_CE, 24'h200);
      st(32'h45);
      `CHK("loop start", 24'h200, tops.loop_start)
      `CHK("loop end", 24'h2ff, tops.loop_end)
      for (int i = 0; i < 3; i++)
      begin
         `CHK("count", 16'(3 - i), tops.count)
         u_dec.drive(mk(SQSC_OP_LOOP_END, 3'b000, SQSC_C_CE, 24'h0));
         #1;
         `CHK("loop exit", (i == 2), loop_exit)
         u_dec.idle();
         #1;
      end
      st(32'h55);
      regs.loop_count_reg <= 16'h1;
      op(SQSC_OP_DO, 3'b000, SQSC_C_FOREVER, 24'h400);
      u_dec.drive(mk(SQSC_OP_LOOP_END, 3'b000, SQSC_C_FOREVER, 24'h0));
      #1;
      `CHK("forever exit", 1'b0, loop_exit)
      u_dec.idle();
      #1;
      `CHK("forever count", 16'h1, tops.count)
      u_dec.set_cond(SQSC_C_NCE);
      #1;
      `CHK("not ce set", 1'b1, cond_true)
      regs.loop_count_reg <= 16'h0;
      for (int i = 0; i < 7; i++)
         op(SQSC_OP_DO, 3'b000, SQSC_C_CE, 24'h500);
      st(32'h65);
      u_dec.set_cond(SQSC_C_NCE);
      #1;
      `CHK("not ce clear", 1'b0, cond_true)
      op(SQSC_OP_DO, 3'b000, SQSC_C_CE, 24'h600);
      st(32'he5);
      reset_dut();
      regs.arith_flags_reg <= 16'h1234;
      regs.mode_flags_reg <= 16'h0056;
      regs.pc_acc <= 24'habcdef;
      op(SQSC_OP_IRQ, 3'b000, SQSC_C_TRUE, 24'h300);
      st(32'h14);
      `CHK("irq pc", 24'h300, tops.pc)
      `CHK("irq arith_flags_reg", 16'h1234, tops.arith_flags_reg)
      `CHK("irq mode_flags_reg", 16'h0056, tops.mode_flags_reg)
      op(SQSC_OP_RTI, 3'b000, SQSC_C_TRUE, 24'h0);
      st(32'h55);
      op(SQSC_OP_PUSH, 3'b100, SQSC_C_TRUE, 24'h0);
      `CHK("push pc", 24'habcdef, tops.pc)
      wb(32'h8, 1'b0, 32'h0);
      `CHK("pc top reg", 32'h00abcdef, rd)
      op(SQSC_OP_POP, 3'b100, SQSC_C_TRUE, 24'h0);
      op(SQSC_OP_PUSH, 3'b001, SQSC_C_TRUE, 24'h0);
      st(32'h15);
      for (int v = 0; v < 32; v++)
      begin
         regs.arith_flags_reg <= 16'(v[3:0]) | (v[4] ? 16'h0040 : 16'h0000);
         foreach (cl[j])
         begin
            u_dec.set_cond(cl[j]);
            #1;
            `CHK(cl[j].name(), cexp(cl[j], regs.arith_flags_reg), cond_true)
         end
      end
      flags <= 14'h2aaa;
      regs.arith_flags_reg <= 16'h0010;
      for (int k = 0; k < 16; k++)
      begin
         wb(32'hc, 1'b1, 32'(k));
         u_dec.set_cond(SQSC_C_SW);
         #1;
         `CHK("sw cond", (k < 14) ? flags[k] : (k == 14), cond_true)
         u_dec.set_cond(SQSC_C_NSW);
         #1;
         `CHK("not sw cond", (k < 14) ? !flags[k] : (k != 14), cond_true)
      end
      for (int k = 0; k < 2; k++)
      begin
         u_dec.set_cond(k == 0 ? SQSC_C_CE : SQSC_C_FOREVER);
         #1;
         `CHK("illegal", 1'b1, cond_ill)
         `CHK("illegal result", 1'b0, cond_true)
      end
      reset_dut();
      irq_pend <= 1'b1;
      wb(32'h4, 1'b1, 32'h400);
      #1;
      `CHK("gie off", 1'b0, irq_ok)
      `CHK("spill irq", 1'b1, stack_irq)
      wb(32'h4, 1'b0, 32'h0);
      `CHK("interrupt_control", 32'h400, rd)
      wb(32'h4, 1'b1, 32'h20);
      #1;
      `CHK("gie on", 1'b1, irq_ok)
      `CHK("spill off", 1'b0, stack_irq)
      stop_test();
   end
endmodule // sequencer_stacks_and_conditions_test
